// >>> cod_pkg.sv
// Package for the operand decoder: opcodes, field layouts, flag positions and operand kinds.
// Assumes an 8-bit core with a 16-bit program counter and a 12-bit register space.
package cod_pkg;

  localparam int BIT_W = 3;
  localparam int DA_W = 16;
  localparam int ER_W = 12;
  localparam int BYTE_W = 8;
  localparam int WREG_W = 4;

  // Opcodes handled by this block
  localparam logic [7:0] OP_ATOMIC = 8'h2F;
  localparam logic [7:0] OP_AND_RR = 8'h52;
  localparam logic [7:0] OP_AND_RIR = 8'h53;
  localparam logic [7:0] OP_AND_GG = 8'h54;
  localparam logic [7:0] OP_AND_GIR = 8'h55;
  localparam logic [7:0] OP_AND_GIM = 8'h56;
  localparam logic [7:0] OP_AND_IRIM = 8'h57;
  localparam logic [7:0] OP_ANDX_EE = 8'h58;
  localparam logic [7:0] OP_ANDX_EIM = 8'h59;

  // Instructions shielded after the atomic prefix
  localparam logic [1:0] ATOMIC_COUNT = 2'h3;

  // Flag bit positions in the flag byte
  localparam int FLAG_C = 7;
  localparam int FLAG_Z = 6;
  localparam int FLAG_S = 5;
  localparam int FLAG_V = 4;
  localparam int FLAG_D = 3;
  localparam int FLAG_H = 2;

  // Working register page sits at the top of the lower register page
  localparam logic [3:0] WREG_PAGE = 4'hE;

  // Per-flag update action
  typedef enum logic [1:0] {
    COD_FLG_KEEP,
    COD_FLG_CALC,
    COD_FLG_ZERO,
    COD_FLG_ONE
  } cod_flg_e;

  // Operand kind selected by the fetch stage
  typedef enum logic [3:0] {
    COD_OPD_BIT,
    COD_OPD_DA,
    COD_OPD_ER,
    COD_OPD_IM,
    COD_OPD_REG,
    COD_OPD_WPAIR,
    COD_OPD_RPAIR,
    COD_OPD_REL,
    COD_OPD_IDX,
    COD_OPD_VEC
  } cod_opd_e;

endpackage : cod_pkg

// >>> cod_flag_unit.sv
// Flag update unit: applies a per-flag action vector to the flag byte.
// Assumes actions and the result arrive together in one cycle.
`timescale 1ns/1ps
`default_nettype none
module cod_flag_unit (
  input  wire logic                  clk,
  input  wire logic                  rst_b,
  input  wire logic                  upd,
  input  wire logic [7:0]            result,
  input  wire logic                  ovf,
  input  wire cod_pkg::cod_flg_e     act_c,
  input  wire cod_pkg::cod_flg_e     act_z,
  input  wire cod_pkg::cod_flg_e     act_s,
  input  wire cod_pkg::cod_flg_e     act_v,
  output logic [7:0]                 flags
);

  typedef struct packed {
    logic [7:0] flags;
  } cod_flu_s;

  cod_flu_s st_r;
  cod_flu_s st_nxt;

  function automatic logic apply(input cod_pkg::cod_flg_e a, input logic old, input logic calc);
    case (a)
      cod_pkg::COD_FLG_CALC: apply = calc;
      cod_pkg::COD_FLG_ZERO: apply = 1'b0;
      cod_pkg::COD_FLG_ONE:  apply = 1'b1;
      default:               apply = old;
    endcase
  endfunction

  always_comb begin
    st_nxt = st_r;
    if (upd) begin
      st_nxt.flags[cod_pkg::FLAG_C] = apply(act_c, st_r.flags[cod_pkg::FLAG_C], 1'b0);
      st_nxt.flags[cod_pkg::FLAG_Z] = apply(act_z, st_r.flags[cod_pkg::FLAG_Z],
                                            result == 8'h00);
      st_nxt.flags[cod_pkg::FLAG_S] = apply(act_s, st_r.flags[cod_pkg::FLAG_S], result[7]);
      st_nxt.flags[cod_pkg::FLAG_V] = apply(act_v, st_r.flags[cod_pkg::FLAG_V], ovf);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign flags = st_r.flags;

endmodule // cod_flag_unit
`default_nettype wire

// >>> cod_atomic_guard.sv
// Atomic guard: blocks interrupt and DMA servicing across a counted run of instructions.
// Assumes instr_done pulses once per completed instruction.
`timescale 1ns/1ps
`default_nettype none
module cod_atomic_guard (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic start,
  input  wire logic instr_done,
  output logic      block
);

  typedef struct packed {
    logic [1:0] cnt;
  } cod_atg_s;

  cod_atg_s st_r;
  cod_atg_s st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (start) begin
      st_nxt.cnt = cod_pkg::ATOMIC_COUNT;
    end else if (instr_done && st_r.cnt != 2'h0) begin
      st_nxt.cnt = st_r.cnt - 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign block = st_r.cnt != 2'h0;

endmodule // cod_atomic_guard
`default_nettype wire

// >>> cod_operand_decode.sv
// Operand decoder: turns operand fields from the fetch stream into addresses and data.
// Assumes the fetch stage presents the opcode, operand kind and raw bytes with a valid strobe.
`timescale 1ns/1ps
`default_nettype none
module cod_operand_decode (
  input  wire logic                  clk,
  input  wire logic                  rst_b,
  input  wire logic                  opd_valid,
  input  wire logic [7:0]            opcode,
  input  wire cod_pkg::cod_opd_e     opd_kind,
  input  wire logic [7:0]            opd_hi,
  input  wire logic [7:0]            opd_lo,
  input  wire logic [15:0]           next_pc,
  input  wire logic [15:0]           base_val,
  input  wire logic                  base_is_pair,
  input  wire logic                  instr_done,
  input  wire logic                  exec_valid,
  input  wire logic [7:0]            exec_result,
  input  wire logic                  irq_req,
  input  wire logic                  dma_req,
  output logic [2:0]                 bit_sel,
  output logic [7:0]                 bit_mask,
  output logic [15:0]                direct_address_operand,
  output logic [11:0]                extended_register_operand,
  output logic [7:0]                 immediate_operand,
  output logic [7:0]                 reg_addr,
  output logic [7:0]                 pair_addr,
  output logic [15:0]                relative_address_operand,
  output logic [15:0]                index_addr,
  output logic [7:0]                 vector_sel,
  output logic                       opd_ok,
  output logic                       opd_err,
  output logic                       irq_grant,
  output logic                       dma_grant,
  output logic                       atomic_block_prefix,
  output logic [7:0]                 flags
);

  typedef struct packed {
    logic [2:0]  bit_sel;
    logic [7:0]  bit_mask;
    logic [15:0] da;
    logic [11:0] er;
    logic [7:0]  im;
    logic [7:0]  reg_addr;
    logic [7:0]  pair_addr;
    logic [15:0] rel;
    logic [15:0] idx;
    logic [7:0]  vec;
    logic        ok;
    logic        err;
    logic        irq_g;
    logic        dma_g;
    logic        atomic;
    logic        and_pend;
  } cod_dec_s;

  cod_dec_s st_r;
  cod_dec_s st_nxt;

  logic                 guard_start;
  logic                 guard_block;
  logic                 flag_upd;
  logic [7:0]           flag_q;
  cod_pkg::cod_flg_e    act_c;
  cod_pkg::cod_flg_e    act_z;
  cod_pkg::cod_flg_e    act_s;
  cod_pkg::cod_flg_e    act_v;

  // Sign-extends a byte displacement and adds it to a 16-bit base
  function automatic logic [15:0] add_disp(input logic [15:0] base, input logic [7:0] disp);
    add_disp = base + {{8{disp[7]}}, disp};
  endfunction

  function automatic logic is_and(input logic [7:0] op);
    is_and = (op >= cod_pkg::OP_AND_RR) && (op <= cod_pkg::OP_ANDX_EIM);
  endfunction

  assign guard_start = opd_valid && opcode == cod_pkg::OP_ATOMIC;

  always_comb begin
    st_nxt = st_r;
    st_nxt.ok = 1'b0;
    st_nxt.err = 1'b0;
    st_nxt.atomic = guard_start || guard_block;
    st_nxt.irq_g = irq_req && !guard_start && !guard_block;
    st_nxt.dma_g = dma_req && !guard_start && !guard_block;
    if (exec_valid) begin
      st_nxt.and_pend = 1'b0;
    end
    if (opd_valid) begin
      st_nxt.ok = 1'b1;
      // Only the latest operand's opcode decides whether the next result touches flags
      st_nxt.and_pend = is_and(opcode);
      case (opd_kind)
        cod_pkg::COD_OPD_BIT: begin
          st_nxt.bit_sel = opd_lo[cod_pkg::BIT_W-1:0];
          st_nxt.bit_mask = 8'h01 << opd_lo[cod_pkg::BIT_W-1:0];
        end
        cod_pkg::COD_OPD_DA: begin
          st_nxt.da = {opd_hi, opd_lo};
        end
        cod_pkg::COD_OPD_ER: begin
          st_nxt.er = {opd_hi[3:0], opd_lo};
        end
        cod_pkg::COD_OPD_IM: begin
          st_nxt.im = opd_lo;
        end
        cod_pkg::COD_OPD_REG: begin
          st_nxt.reg_addr = opd_lo;
        end
        cod_pkg::COD_OPD_WPAIR: begin
          if (opd_lo[0]) begin
            st_nxt.ok = 1'b0;
            st_nxt.err = 1'b1;
          end else begin
            st_nxt.pair_addr = {cod_pkg::WREG_PAGE, opd_lo[3:0]};
          end
        end
        cod_pkg::COD_OPD_RPAIR: begin
          if (opd_lo[0]) begin
            st_nxt.ok = 1'b0;
            st_nxt.err = 1'b1;
          end else begin
            st_nxt.pair_addr = opd_lo;
          end
        end
        cod_pkg::COD_OPD_REL: begin
          st_nxt.rel = add_disp(next_pc, opd_lo);
        end
        cod_pkg::COD_OPD_IDX: begin
          if (base_is_pair) begin
            st_nxt.idx = add_disp(base_val, opd_lo);
          end else begin
            st_nxt.idx = {8'h00, 8'(base_val[7:0] + opd_lo)};
          end
        end
        cod_pkg::COD_OPD_VEC: begin
          st_nxt.vec = opd_lo;
        end
        default: begin
          st_nxt.ok = 1'b0;
          st_nxt.err = 1'b1;
        end
      endcase
    end
  end

  // Only AND results update flags here; all other opcodes leave them alone
  always_comb begin
    flag_upd = exec_valid && st_r.and_pend;
    act_c = cod_pkg::COD_FLG_KEEP;
    act_z = cod_pkg::COD_FLG_CALC;
    act_s = cod_pkg::COD_FLG_CALC;
    act_v = cod_pkg::COD_FLG_ZERO;
  end

  cod_atomic_guard u_guard (
    .clk        (clk),
    .rst_b      (rst_b),
    .start      (guard_start),
    .instr_done (instr_done),
    .block      (guard_block)
  );

  cod_flag_unit u_flags (
    .clk    (clk),
    .rst_b  (rst_b),
    .upd    (flag_upd),
    .result (exec_result),
    .ovf    (1'b0),
    .act_c  (act_c),
    .act_z  (act_z),
    .act_s  (act_s),
    .act_v  (act_v),
    .flags  (flag_q)
  );

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign bit_sel = st_r.bit_sel;
  assign bit_mask = st_r.bit_mask;
  assign direct_address_operand = st_r.da;
  assign extended_register_operand = st_r.er;
  assign immediate_operand = st_r.im;
  assign reg_addr = st_r.reg_addr;
  assign pair_addr = st_r.pair_addr;
  assign relative_address_operand = st_r.rel;
  assign index_addr = st_r.idx;
  assign vector_sel = st_r.vec;
  assign opd_ok = st_r.ok;
  assign opd_err = st_r.err;
  assign irq_grant = st_r.irq_g;
  assign dma_grant = st_r.dma_g;
  assign atomic_block_prefix = st_r.atomic;
  assign flags = flag_q;

endmodule // cod_operand_decode
`default_nettype wire

// >>> cod_operand_decode_props.sv
// Checker for the operand decoder, bound to the decoder's ports.
// Assumes one clock domain with a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module cod_chk (
  input wire logic              clk,
  input wire logic              rst_b,
  input wire logic              opd_valid,
  input wire logic [7:0]        opcode,
  input wire cod_pkg::cod_opd_e opd_kind,
  input wire logic [7:0]        opd_hi,
  input wire logic [7:0]        opd_lo,
  input wire logic [15:0]       next_pc,
  input wire logic              exec_valid,
  input wire logic [7:0]        exec_result,
  input wire logic              irq_req,
  input wire logic              irq_grant,
  input wire logic              dma_grant,
  input wire logic              atomic_block_prefix,
  input wire logic [7:0]        flags,
  input wire logic [7:0]        bit_mask,
  input wire logic [15:0]       direct_address_operand,
  input wire logic [15:0]       relative_address_operand,
  input wire logic [7:0]        pair_addr,
  input wire logic              opd_err
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic        and_r;
  logic        and_op;
  logic [7:0]  bm_exp;
  logic [15:0] da_exp;
  logic [15:0] rel_exp;
  logic [1:0]  zs_exp;
  logic [2:0]  kept;
  // An AND operand arms one flag update, which the next result consumes
  always_ff @(posedge clk) begin
    if (!rst_b)
      and_r <= 1'b0;
    else if (opd_valid)
      and_r <= (opcode >= cod_pkg::OP_AND_RR) && (opcode <= cod_pkg::OP_ANDX_EIM);
    else if (exec_valid)
      and_r <= 1'b0;
  end
  assign and_op  = and_r;
  assign bm_exp  = 8'h01 << opd_lo[2:0];
  assign da_exp  = {opd_hi, opd_lo};
  assign rel_exp = next_pc + {{8{opd_lo[7]}}, opd_lo};
  assign zs_exp  = {exec_result == 8'h00, exec_result[7]};
  assign kept    = {flags[7], flags[3], flags[2]};
  a_bit_mask: assert property (
    opd_valid && opd_kind == cod_pkg::COD_OPD_BIT |=> bit_mask == $past(bm_exp))
    else $error("bit mask wrong");
  a_direct_full: assert property (
    opd_valid && opd_kind == cod_pkg::COD_OPD_DA |=> direct_address_operand == $past(da_exp))
    else $error("direct address wrong");
  a_rel_target: assert property (
    opd_valid && opd_kind == cod_pkg::COD_OPD_REL |=> relative_address_operand == $past(rel_exp))
    else $error("relative target wrong");
  a_pair_odd: assert property (
    opd_valid && opd_lo[0] && (opd_kind == cod_pkg::COD_OPD_WPAIR ||
    opd_kind == cod_pkg::COD_OPD_RPAIR) |=> opd_err && $stable(pair_addr))
    else $error("odd pair accepted");
  a_atomic_start: assert property (
    opd_valid && opcode == cod_pkg::OP_ATOMIC |=> atomic_block_prefix && $stable(flags))
    else $error("atomic window not opened");
  a_atomic_hold: assert property (
    atomic_block_prefix |-> !irq_grant && !dma_grant)
    else $error("grant inside atomic window");
  a_grant_cause: assert property (
    irq_grant |-> $past(irq_req))
    else $error("grant without request");
  a_and_flags: assert property (
    exec_valid && and_op |=> flags[6:5] == $past(zs_exp) && !flags[4] && $stable(kept))
    else $error("logical flags wrong");
  a_other_flags: assert property (
    exec_valid && !and_op |=> $stable(flags))
    else $error("flags changed");
  c_atomic: cover property (opd_valid && opcode == cod_pkg::OP_ATOMIC);
  c_and: cover property (exec_valid && and_op);
  c_err: cover property (opd_err);
endmodule // cod_chk
bind cod_operand_decode cod_chk chk_u (.clk, .rst_b, .opd_valid, .opcode, .opd_kind, .opd_hi,
  .opd_lo, .next_pc, .exec_valid, .exec_result, .irq_req, .irq_grant, .dma_grant,
  .atomic_block_prefix, .flags, .bit_mask, .direct_address_operand,
  .relative_address_operand, .pair_addr, .opd_err);
`default_nettype wire

// >>> tb.sv
// Self-checking bench for the operand decoder: random operands and corner cases.
// Assumes the checker file binds itself to the decoder.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 1'b0, rst_b = 1'b0, opd_valid = 1'b0, base_is_pair = 1'b0;
  logic instr_done = 1'b0, exec_valid = 1'b0, irq_req = 1'b0, dma_req = 1'b0;
  logic [7:0] opcode = 8'h00, opd_hi = 8'h00, opd_lo = 8'h00, exec_result = 8'h00;
  logic [15:0] next_pc = 16'h0000, base_val = 16'h0000;
  cod_pkg::cod_opd_e opd_kind = cod_pkg::COD_OPD_BIT;
  logic [2:0] bit_sel;
  logic [7:0] bit_mask, immediate_operand, reg_addr, pair_addr, vector_sel, flags;
  logic [15:0] direct_address_operand, relative_address_operand, index_addr;
  logic [11:0] extended_register_operand;
  logic opd_ok, opd_err, irq_grant, dma_grant, atomic_block_prefix;
  logic [7:0] flag_exp = 8'h00, pexp = 8'h00;
  logic [7:0] cor [4] = '{8'h00, 8'h7F, 8'h80, 8'hFF};
  int error_cnt = 0, cmp_count = 0;
  cod_operand_decode dut_u (.clk, .rst_b, .opd_valid, .opcode, .opd_kind, .opd_hi, .opd_lo,
    .next_pc, .base_val, .base_is_pair, .instr_done, .exec_valid, .exec_result, .irq_req,
    .dma_req, .bit_sel, .bit_mask, .direct_address_operand, .extended_register_operand,
    .immediate_operand, .reg_addr, .pair_addr, .relative_address_operand, .index_addr,
    .vector_sel, .opd_ok, .opd_err, .irq_grant, .dma_grant, .atomic_block_prefix, .flags);
  always #12.5 clk = ~clk;
  function automatic logic [7:0] and_flags(input logic [7:0] f, input logic [7:0] r);
    return {f[7], r == 8'h00, r[7], 1'b0, f[3:0]};
  endfunction
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic summarize;
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic opd(input cod_pkg::cod_opd_e k, input logic [7:0] oc, hi, lo);
    logic [15:0] sx;
    logic        err;
    @(posedge clk);
    opd_valid <= 1'b1;
    opd_kind <= k;
    opcode <= oc;
    opd_hi <= hi;
    opd_lo <= lo;
    next_pc <= 16'($urandom);
    base_val <= 16'($urandom);
    base_is_pair <= 1'($urandom);
    @(posedge clk);
    opd_valid <= 1'b0;
    #1;
    sx = {{8{lo[7]}}, lo};
    err = (lo[0] && (k == cod_pkg::COD_OPD_WPAIR || k == cod_pkg::COD_OPD_RPAIR)) ||
          k > cod_pkg::COD_OPD_VEC;
    if (!err && k == cod_pkg::COD_OPD_WPAIR)
      pexp = {4'hE, lo[3:0]};
    if (!err && k == cod_pkg::COD_OPD_RPAIR)
      pexp = lo;
    case (k)
      cod_pkg::COD_OPD_BIT: chk("bit", {5'h00, lo[2:0], 8'h01 << lo[2:0]},
                                {5'h00, bit_sel, bit_mask});
      cod_pkg::COD_OPD_DA: chk("da", {hi, lo}, direct_address_operand);
      cod_pkg::COD_OPD_ER: chk("er", {4'h0, hi[3:0], lo}, 16'(extended_register_operand));
      cod_pkg::COD_OPD_IM: chk("im", 16'(lo), 16'(immediate_operand));
      cod_pkg::COD_OPD_REG: chk("reg", 16'(lo), 16'(reg_addr));
      cod_pkg::COD_OPD_REL: chk("rel", next_pc + sx, relative_address_operand);
      cod_pkg::COD_OPD_IDX: chk("idx", base_is_pair ? base_val + sx :
        {8'h00, 8'(base_val[7:0] + lo)}, index_addr);
      cod_pkg::COD_OPD_VEC: chk("vec", 16'(lo), 16'(vector_sel));
      default: chk("pair", {7'h00, err, pexp}, {7'h00, opd_err, pair_addr});
    endcase
    chk("ok", 16'({!err, err}), 16'({opd_ok, opd_err}));
  endtask
  task automatic exec(input logic is_and, input logic [7:0] r);
    @(posedge clk);
    exec_valid <= 1'b1;
    exec_result <= r;
    @(posedge clk);
    exec_valid <= 1'b0;
    #1;
    if (is_and)
      flag_exp = and_flags(flag_exp, r);
    chk("flags", 16'(flag_exp), 16'(flags));
  endtask
  task automatic done_pulse;
    @(posedge clk);
    instr_done <= 1'b1;
    @(posedge clk);
    instr_done <= 1'b0;
    #1;
  endtask
  task automatic gate(input logic [2:0] e);
    chk("gate", 16'(e), 16'({atomic_block_prefix, irq_grant, dma_grant}));
  endtask
  initial begin
    void'($urandom(16));
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    #1;
    chk("rst", 16'({flags, atomic_block_prefix, opd_ok}), 16'h0000);
    for (int i = 0; i < 80; i++) begin
      opd(cod_pkg::cod_opd_e'(i < 40 ? i % 10 : $urandom_range(9)), 8'h00, 8'($urandom),
          i < 40 ? cor[i / 10] : 8'($urandom));
    end
    // A kind code outside the defined set must be refused
    opd(cod_pkg::cod_opd_e'(4'hA), 8'h00, 8'h00, 8'h00);
    for (int j = 0; j < 8; j++) begin
      opd(cod_pkg::COD_OPD_IM, 8'(cod_pkg::OP_AND_RR + j), 8'h00, 8'($urandom));
      exec(1'b1, j == 0 ? 8'h00 : j == 1 ? 8'h80 : 8'($urandom));
    end
    opd(cod_pkg::COD_OPD_IM, 8'h12, 8'h00, 8'h00);
    exec(1'b0, 8'h00);
    @(posedge clk);
    irq_req <= 1'b1;
    dma_req <= 1'b1;
    opd(cod_pkg::COD_OPD_IM, cod_pkg::OP_ATOMIC, 8'h00, 8'h00);
    gate(3'b100);
    done_pulse();
    done_pulse();
    opd(cod_pkg::COD_OPD_IM, cod_pkg::OP_ATOMIC, 8'h00, 8'h00);
    done_pulse();
    done_pulse();
    gate(3'b100);
    done_pulse();
    repeat (2) @(posedge clk);
    #1;
    gate(3'b011);
    summarize();
  end
  initial begin
    repeat (3000) @(posedge clk);
    error_cnt++;
    summarize();
  end
endmodule // tb
`default_nettype wire
